//--- rtl/pdp_pkg.sv
// Functional notes
// - e_wr low: sclk shifts into primary
// - e_wr high: sclk shifts into auxiliary
// - serial mode: serial_bank_select picks primary/secondary
// - parallel mode: parallel_bank_select picks primary/secondary
// - prescaler enable active low; high bypasses
// - parallel e_wr rise latches byte into auxiliary
// - main_high_write rise loads ref[5:4], main[8:7]
// - main_low_write rise loads prescaler enable, main[6:0]
// - ref_swallow_write rise loads ref[3:0], swallow
// - hop write rise copies primary to secondary
// - direct 0: serial select 1 serial, 0 parallel
// - direct mode takes counters from dedicated pins
// - direct swallow is four pins, bit3 MSB
// - parallel bus 8 bits, bit7 MSB
// - monitor follows main divider, auxiliary can stop
// - s_wr low shifts; s_wr rise loads primary and secondary
// - auxiliary bits act only while feature enable low
package pdp_pkg;
  localparam int PRI_W = 20;
  localparam int AUX_W = 8;
  localparam int BUS_W = 8;
  localparam int REF_W = 6;
  localparam int MAIN_W = 9;
  localparam int SWAL_W = 4;
  localparam int DIR_REF_W = 4;
  // parallel byte layouts
  localparam int MH_MAIN_LSB = 0;
  localparam int MH_REF_LSB = 2;
  localparam int ML_MAIN_LSB = 0;
  localparam int ML_PRE_BIT = 7;
  localparam int RS_SWAL_LSB = 0;
  localparam int RS_REF_LSB = 4;
  localparam int HI_FIELD_W = 2;
  localparam int LO_MAIN_W = 7;
  // auxiliary register bit that silences the monitor output
  localparam int AUX_MON_OFF_BIT = 0;
  localparam logic [PRI_W-1:0] PRI_RST = 20'h00000;
  localparam logic [AUX_W-1:0] AUX_RST = 8'h00;

  // field order is also the serial shift order, ref_div[5] first
  typedef struct packed {
    logic [REF_W-1:0] ref_div;
    logic [MAIN_W-1:0] main_div;
    logic pre_en_n;
    logic [SWAL_W-1:0] swallow;
  } pdp_div_type;

  typedef struct packed {
    logic s_wr;
    logic e_wr;
    logic main_high_write;
    logic main_low_write;
    logic ref_swallow_write;
    logic hop_write;
    logic direct_mode_sel;
    logic serial_mode_sel;
    logic serial_bank_select;
    logic parallel_bank_select;
    logic feature_enable_n;
    logic [BUS_W-1:0] pdata;
    logic [DIR_REF_W-1:0] direct_ref;
    logic [MAIN_W-1:0] direct_main;
    logic [SWAL_W-1:0] direct_swallow;
    logic direct_pre_en_n;
  } pdp_pins_type;

  typedef enum logic [2:0] {
    PDP_DIRECT = 3'b001,
    PDP_SERIAL = 3'b010,
    PDP_PARALLEL = 3'b100
  } pdp_mode_type;
endpackage

//--- rtl/pdp_program_port.sv
`timescale 1ns/100ps
module pdp_program_port
  import pdp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic sdata,
  input wire pdp_pins_type pins,
  input wire logic main_div_out,
  output pdp_div_type counters_q,
  output logic prescaler_bypass_q,
  output logic [AUX_W-1:0] aux_active_q,
  output logic monitor_q,
  output pdp_mode_type mode_q
);

  function automatic logic rise(input logic now_v, input logic was_v);
    return now_v & ~was_v;
  endfunction

  // bank select: 1 takes the primary word, 0 the secondary
  function automatic pdp_div_type pick_word(input logic sel, input pdp_div_type pri,
    input pdp_div_type sec);
    return sel ? pri : sec;
  endfunction

  // ---------------- link (sclk) domain ----------------
  logic srst_meta_q;
  logic srst_n_q;
  logic [PRI_W-1:0] sh_pri_q;
  logic [AUX_W-1:0] sh_aux_q;

  // sclk may stop between frames; reset reaches the shifters on its next edges
  always_ff @(posedge sclk) begin
    srst_meta_q <= rst_n;
    srst_n_q <= srst_meta_q;
  end

  // shifting outranks the link reset: sclk is usually stopped when rst_n rises, so the
  // synchronised reset is still low on the first two edges of the next frame
  always_ff @(posedge sclk) begin
    if (!pins.e_wr && !pins.s_wr) begin
      sh_pri_q <= {sh_pri_q[PRI_W-2:0], sdata};
    end else if (!srst_n_q) begin
      sh_pri_q <= PRI_RST;
    end
  end

  always_ff @(posedge sclk) begin
    if (pins.e_wr) begin
      sh_aux_q <= {sh_aux_q[AUX_W-2:0], sdata};
    end else if (!srst_n_q) begin
      sh_aux_q <= AUX_RST;
    end
  end

  // ---------------- system (clk) domain ----------------
  pdp_pins_type pins_meta_q;
  pdp_pins_type pins_q;
  pdp_pins_type prev_q;
  pdp_div_type primary_q;
  pdp_div_type secondary_q;
  logic [AUX_W-1:0] aux_q;
  pdp_mode_type mode_d;
  logic ser_mode;
  logic par_mode;
  logic s_wr_rise;
  logic e_wr_rise;
  logic e_wr_fall;
  logic hop_rise;
  logic mh_rise;
  logic ml_rise;
  logic rs_rise;
  pdp_div_type direct_word;
  pdp_div_type counters_d;
  logic [AUX_W-1:0] aux_active_d;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pins_meta_q <= '0;
      pins_q <= '0;
      prev_q <= '0;
    end else begin
      pins_meta_q <= pins;
      pins_q <= pins_meta_q;
      prev_q <= pins_q;
    end
  end

  always_comb begin
    if (pins_q.direct_mode_sel) begin
      mode_d = PDP_DIRECT;
    end else if (pins_q.serial_mode_sel) begin
      mode_d = PDP_SERIAL;
    end else begin
      mode_d = PDP_PARALLEL;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_q <= PDP_PARALLEL;
    end else begin
      mode_q <= mode_d;
    end
  end

  // strobes are judged against the registered mode; selects must stay put while programming
  assign ser_mode = (mode_q == PDP_SERIAL);
  assign par_mode = (mode_q == PDP_PARALLEL);
  assign s_wr_rise = ser_mode & rise(pins_q.s_wr, prev_q.s_wr);
  assign e_wr_rise = par_mode & rise(pins_q.e_wr, prev_q.e_wr);
  assign e_wr_fall = ser_mode & rise(prev_q.e_wr, pins_q.e_wr);
  assign hop_rise = (ser_mode | par_mode) & rise(pins_q.hop_write, prev_q.hop_write);
  assign mh_rise = par_mode & rise(pins_q.main_high_write, prev_q.main_high_write);
  assign ml_rise = par_mode & rise(pins_q.main_low_write, prev_q.main_low_write);
  assign rs_rise = par_mode & rise(pins_q.ref_swallow_write, prev_q.ref_swallow_write);

  // sh_pri_q is only sampled once s_wr has been high for two clk edges, so it is still
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      primary_q <= PRI_RST;
    end else if (s_wr_rise) begin
      primary_q <= sh_pri_q;
    end else begin
      if (mh_rise) begin
        primary_q.ref_div[REF_W-1 -: HI_FIELD_W] <=
          pins_q.pdata[MH_REF_LSB +: HI_FIELD_W];
        primary_q.main_div[MAIN_W-1 -: HI_FIELD_W] <=
          pins_q.pdata[MH_MAIN_LSB +: HI_FIELD_W];
      end
      if (ml_rise) begin
        primary_q.pre_en_n <= pins_q.pdata[ML_PRE_BIT];
        primary_q.main_div[LO_MAIN_W-1:0] <= pins_q.pdata[ML_MAIN_LSB +: LO_MAIN_W];
      end
      if (rs_rise) begin
        primary_q.ref_div[SWAL_W-1:0] <= pins_q.pdata[RS_REF_LSB +: SWAL_W];
        primary_q.swallow <= pins_q.pdata[RS_SWAL_LSB +: SWAL_W];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      secondary_q <= PRI_RST;
    end else if (s_wr_rise) begin
      secondary_q <= sh_pri_q;
    end else if (hop_rise) begin
      secondary_q <= primary_q;
    end
  end

  // serial auxiliary word is taken when e_wr drops and the shifter is quiet
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aux_q <= AUX_RST;
    end else if (e_wr_rise) begin
      aux_q <= pins_q.pdata;
    end else if (e_wr_fall) begin
      aux_q <= sh_aux_q;
    end
  end

  always_comb begin
    direct_word = '0;
    direct_word.ref_div[DIR_REF_W-1:0] = pins_q.direct_ref;
    direct_word.main_div = pins_q.direct_main;
    direct_word.pre_en_n = pins_q.direct_pre_en_n;
    direct_word.swallow = pins_q.direct_swallow;
  end

  always_comb begin
    unique case (mode_q)
      PDP_DIRECT: counters_d = direct_word;
      PDP_SERIAL: counters_d = pick_word(pins_q.serial_bank_select, primary_q, secondary_q);
      PDP_PARALLEL: counters_d = pick_word(pins_q.parallel_bank_select, primary_q,
        secondary_q);
      default: counters_d = secondary_q;
    endcase
  end

  // enhancement bits have no meaning in direct mode
  assign aux_active_d = (!pins_q.feature_enable_n && !pins_q.direct_mode_sel) ?
                        aux_q : AUX_RST;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      counters_q <= PRI_RST;
      prescaler_bypass_q <= 1'b0;
    end else begin
      counters_q <= counters_d;
      prescaler_bypass_q <= counters_d.pre_en_n;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aux_active_q <= AUX_RST;
      monitor_q <= 1'b0;
    end else begin
      aux_active_q <= aux_active_d;
      monitor_q <= main_div_out & ~aux_active_d[AUX_MON_OFF_BIT];
    end
  end

endmodule

//--- bench/pdp_program_port_monitor.sv
`timescale 1ns/100ps
module pdp_program_port_monitor
  import pdp_pkg::*;
(
  input logic clk,
  input logic rst_n,
  input logic sclk,
  input logic sdata,
  input pdp_pins_type pins,
  input logic main_div_out,
  input pdp_div_type counters_q,
  input logic prescaler_bypass_q,
  input logic [AUX_W-1:0] aux_active_q,
  input logic monitor_q,
  input pdp_mode_type mode_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_reset_values: assert property ($rose(rst_n) |->
    counters_q == PRI_RST && mode_q == PDP_PARALLEL) else $error("bad reset state");
  chk_bypass_level: assert property ($stable(counters_q) |->
    prescaler_bypass_q == counters_q.pre_en_n) else $error("bypass wrong");
  chk_monitor_off: assert property (aux_active_q[0] && $past(aux_active_q[0]) |->
    !monitor_q) else $error("monitor not silenced");
  chk_monitor_runs: assert property ($past(rst_n) && !aux_active_q[0] &&
    !$past(aux_active_q[0]) |-> monitor_q == $past(main_div_out)) else $error("monitor stuck");
  chk_serial_mode: assert property ((!pins.direct_mode_sel && pins.serial_mode_sel)[*5] |->
    mode_q == PDP_SERIAL) else $error("mode wrong");
  chk_direct_word: assert property ((pins.direct_mode_sel && $stable(pins))[*6] |->
    counters_q == {2'b00, pins.direct_ref, pins.direct_main, pins.direct_pre_en_n,
    pins.direct_swallow}) else $error("direct word wrong");
  chk_counter_hold: assert property (($stable(pins) && !pins.serial_mode_sel &&
    !pins.serial_bank_select)[*6] |->
    $stable(counters_q)) else $error("counters moved");
  chk_aux_gated: assert property (pins.feature_enable_n[*5] |->
    aux_active_q == 8'h00) else $error("aux active");
  cover property (mode_q == PDP_SERIAL);
  cover property (aux_active_q[0]);
  cover property ($rose(monitor_q));
endmodule
bind pdp_program_port pdp_program_port_monitor i_mon (.clk, .rst_n, .sclk, .sdata, .pins,
  .main_div_out, .counters_q, .prescaler_bypass_q, .aux_active_q, .monitor_q, .mode_q);

//--- bench/pdp_ctrl_model.sv
`timescale 1ns/100ps
module pdp_ctrl_model (
  output logic sclk,
  output logic sdata,
  output logic s_wr,
  output logic e_wr
);
  // free edges only so the shifters see reset
  initial begin
    {sclk, sdata, s_wr, e_wr} = 4'h2;
    repeat (8) #15 sclk = ~sclk;
  end
  task automatic frame(input logic [19:0] w, input int n, input logic aux);
    #7;
    if (aux) e_wr = 1'b1;
    else s_wr = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin // msb first
      sdata = w[i];
      #15 sclk = 1'b1;
      #15 sclk = 1'b0;
    end
    sdata = 1'b0;
    #60 {s_wr, e_wr} = 2'h2;
    #600;
  endtask
endmodule

//--- bench/pll_divider_program_port_test.sv
`timescale 1ns/100ps
module pll_divider_program_port_test;
  import pdp_pkg::*;
  logic clk, rst_n, sclk, sdata, m_swr, m_ewr, mdo;
  logic prescaler_bypass_q, monitor_q;
  logic [AUX_W-1:0] aux_active_q;
  pdp_pins_type p, pins;
  pdp_div_type counters_q, e;
  pdp_mode_type mode_q;
  int bad_count, n_checks;
  always_comb begin
    pins = p;
    pins.s_wr = m_swr;
    pins.e_wr = p.e_wr | m_ewr;
  end
  pdp_program_port i_dut (.clk, .rst_n, .sclk, .sdata, .pins, .main_div_out(mdo),
    .counters_q, .prescaler_bypass_q, .aux_active_q, .monitor_q, .mode_q);
  pdp_ctrl_model i_ctl (.sclk, .sdata, .s_wr(m_swr), .e_wr(m_ewr));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) mdo <= ~mdo;
  task automatic chk(input logic [19:0] g, input logic [19:0] x);
    n_checks++;
    if (g !== x) begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, g, x);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // a frame ends off the clock edge; realign so later stimulus lands on a rising edge
  task automatic ser(input logic [19:0] w, input int n, input logic aux);
    i_ctl.frame(w, n, aux);
    cyc(1);
  endtask
  // s = {hop, aux, main_high, main_low, ref_swallow}
  task automatic wr(input logic [4:0] s, input logic [7:0] d);
    p.pdata <= d;
    cyc(3);
    {p.hop_write, p.e_wr, p.main_high_write, p.main_low_write, p.ref_swallow_write} <= s;
    cyc(3);
    {p.hop_write, p.e_wr, p.main_high_write, p.main_low_write, p.ref_swallow_write} <= 5'h00;
    cyc(6);
  endtask
  task automatic t_parallel;
    e = {6'h29, 9'h1c5, 1'b1, 4'ha};
    p.parallel_bank_select <= 1'b1;
    wr(5'h04, 8'h0b);
    wr(5'h02, 8'hc5);
    wr(5'h01, 8'h9a);
    chk(counters_q, e);
    chk({19'h00000, prescaler_bypass_q}, 20'h00001);
    wr(5'h10, 8'h00);
    wr(5'h02, 8'h01);
    p.parallel_bank_select <= 1'b0;
    cyc(6);
    chk(counters_q, e);
    p.parallel_bank_select <= 1'b1;
    cyc(6);
    chk(counters_q, {6'h29, 9'h181, 1'b0, 4'ha});
    p.feature_enable_n <= 1'b0;
    wr(5'h08, 8'h81);
    chk({12'h000, aux_active_q}, 20'h00081);
    chk({19'h00000, monitor_q}, 20'h00000);
    p.feature_enable_n <= 1'b1;
    cyc(6);
    chk({12'h000, aux_active_q}, 20'h00000);
  endtask
  task automatic t_serial;
    p.serial_mode_sel <= 1'b1;
    p.serial_bank_select <= 1'b1;
    p.feature_enable_n <= 1'b0;
    cyc(6);
    chk({17'h00000, mode_q}, {17'h00000, PDP_SERIAL});
    ser(20'h5a3c7, 20, 1'b0);
    chk(counters_q, 20'h5a3c7);
    wr(5'h02, 8'hff);
    chk(counters_q, 20'h5a3c7);
    p.serial_bank_select <= 1'b0;
    cyc(6);
    chk(counters_q, 20'h5a3c7);
    ser(20'h0003c, 8, 1'b1);
    chk({12'h000, aux_active_q}, 20'h0003c);
  endtask
  task automatic t_direct;
    e = {2'b00, 4'h9, 9'h133, 1'b1, 4'h8};
    p.direct_ref <= 4'h9;
    p.direct_main <= 9'h133;
    p.direct_pre_en_n <= 1'b1;
    p.direct_swallow <= 4'h8;
    p.direct_mode_sel <= 1'b1;
    cyc(8);
    chk(counters_q, e);
    chk({17'h00000, mode_q}, {17'h00000, PDP_DIRECT});
    ser(20'hfffff, 20, 1'b0);
    chk(counters_q, e);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    mdo = 1'b0;
    p = '0;
    bad_count = 0;
    n_checks = 0;
    cyc(20);
    rst_n <= 1'b1;
    cyc(4);
    t_parallel();
    t_serial();
    t_direct();
    report_and_stop();
  end
endmodule
